// *** core/jtb_consts.vh ***
// constants for the boundary-scan test access port
`ifndef JTB_CONSTS_VH
`define JTB_CONSTS_VH

// ==========================================
// tap states
`define JTB_ST_RESET      4'h0
`define JTB_ST_IDLE       4'h1
`define JTB_ST_SEL_DR     4'h2
`define JTB_ST_CAP_DR     4'h3
`define JTB_ST_SHIFT_DR   4'h4
`define JTB_ST_EXIT1_DR   4'h5
`define JTB_ST_PAUSE_DR   4'h6
`define JTB_ST_EXIT2_DR   4'h7
`define JTB_ST_UPD_DR     4'h8
`define JTB_ST_SEL_IR     4'h9
`define JTB_ST_CAP_IR     4'ha
`define JTB_ST_SHIFT_IR   4'hb
`define JTB_ST_EXIT1_IR   4'hc
`define JTB_ST_PAUSE_IR   4'hd
`define JTB_ST_EXIT2_IR   4'he
`define JTB_ST_UPD_IR     4'hf

// ==========================================
// instruction codes, six bits
`define JTB_IR_W          6
`define JTB_OP_EXTEST     6'h00
`define JTB_OP_SAMPLE     6'h01
`define JTB_OP_IDCODE     6'h02
`define JTB_OP_BYPASS     6'h3f
// value loaded into the instruction shift path at capture
`define JTB_IR_CAPTURE    6'h01

// ==========================================
// identification register, value arbitrary
`define JTB_IDCODE        32'h1234_5001

`endif

// *** core/jtb_tap.v ***
// boundary-scan test access port: tap controller, instruction, id, bypass and boundary chain
// ==========================================
`timescale 1ns/1ps
`include "jtb_consts.vh"

module jtb_tap #(
	parameter CHAIN_W = 8
)(
	// clock and reset
	input  wire               mclk_i,
	input  wire               rst_n_i,
	// test port pins
	input  wire               tck_i,
	input  wire               tms_i,
	input  wire               tdi_i,
	input  wire               trst_n_i,
	output reg                tdo_o,
	output reg                tdo_oe_o,
	// core side of the boundary cells
	// pad levels pass a synchroniser before capture
	input  wire [CHAIN_W-1:0] pin_in_i,
	input  wire [CHAIN_W-1:0] core_out_i,
	output reg  [CHAIN_W-1:0] pin_out_o,
	output reg                extest_o
);

	// ==========================================
	// input synchronisers
	reg [1:0] tck_s;
	reg [1:0] tms_s;
	reg [1:0] tdi_s;
	reg [1:0] trst_s;
	reg       tck_d;
	wire      rise;
	wire      fall;

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tck_s  <= 2'h0;
			tms_s  <= 2'h3;
			tdi_s  <= 2'h3;
			trst_s <= 2'h0;
			tck_d  <= 1'b0;
		end
		else
		begin
			tck_s  <= {tck_s[0], tck_i};
			tms_s  <= {tms_s[0], tms_i};
			tdi_s  <= {tdi_s[0], tdi_i};
			trst_s <= {trst_s[0], trst_n_i};
			tck_d  <= tck_s[1];
		end
	end

	assign rise = tck_s[1] & ~tck_d;
	assign fall = ~tck_s[1] & tck_d;

	// ==========================================
	// pad synchroniser for the boundary capture
	// pads move freely against mclk, so they get the same two flops as the port pins
	reg [CHAIN_W-1:0] pin_s0;
	reg [CHAIN_W-1:0] pin_s1;

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_s0 <= {CHAIN_W{1'b0}};
			pin_s1 <= {CHAIN_W{1'b0}};
		end
		else
		begin
			pin_s0 <= pin_in_i;
			pin_s1 <= pin_s0;
		end
	end

	// ==========================================
	// tap state machine
	reg [3:0] state;
	reg [3:0] next_state;

	always @*
	begin
		case (state)
			`JTB_ST_RESET:
				next_state = tms_s[1] ? `JTB_ST_RESET : `JTB_ST_IDLE;
			`JTB_ST_IDLE:
				next_state = tms_s[1] ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
			`JTB_ST_SEL_DR:
				next_state = tms_s[1] ? `JTB_ST_SEL_IR : `JTB_ST_CAP_DR;
			`JTB_ST_CAP_DR:
				next_state = tms_s[1] ? `JTB_ST_EXIT1_DR : `JTB_ST_SHIFT_DR;
			`JTB_ST_SHIFT_DR:
				next_state = tms_s[1] ? `JTB_ST_EXIT1_DR : `JTB_ST_SHIFT_DR;
			`JTB_ST_EXIT1_DR:
				next_state = tms_s[1] ? `JTB_ST_UPD_DR : `JTB_ST_PAUSE_DR;
			`JTB_ST_PAUSE_DR:
				next_state = tms_s[1] ? `JTB_ST_EXIT2_DR : `JTB_ST_PAUSE_DR;
			`JTB_ST_EXIT2_DR:
				next_state = tms_s[1] ? `JTB_ST_UPD_DR : `JTB_ST_SHIFT_DR;
			`JTB_ST_UPD_DR:
				next_state = tms_s[1] ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
			`JTB_ST_SEL_IR:
				next_state = tms_s[1] ? `JTB_ST_RESET : `JTB_ST_CAP_IR;
			`JTB_ST_CAP_IR:
				next_state = tms_s[1] ? `JTB_ST_EXIT1_IR : `JTB_ST_SHIFT_IR;
			`JTB_ST_SHIFT_IR:
				next_state = tms_s[1] ? `JTB_ST_EXIT1_IR : `JTB_ST_SHIFT_IR;
			`JTB_ST_EXIT1_IR:
				next_state = tms_s[1] ? `JTB_ST_UPD_IR : `JTB_ST_PAUSE_IR;
			`JTB_ST_PAUSE_IR:
				next_state = tms_s[1] ? `JTB_ST_EXIT2_IR : `JTB_ST_PAUSE_IR;
			`JTB_ST_EXIT2_IR:
				next_state = tms_s[1] ? `JTB_ST_UPD_IR : `JTB_ST_SHIFT_IR;
			`JTB_ST_UPD_IR:
				next_state = tms_s[1] ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
			// codes outside the sixteen fall back to reset
			default:
				next_state = `JTB_ST_RESET;
		endcase
	end

	// test reset acts without test clock via the synchronised level held low
	// one step per sampled rising edge
	// five ones always land in reset
	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= `JTB_ST_RESET;
		else if (!trst_s[1])
			state <= `JTB_ST_RESET;
		else if (rise)
			state <= next_state;
	end

	// ==========================================
	// instruction register
	reg [`JTB_IR_W-1:0] ir_shift;
	reg [`JTB_IR_W-1:0] ir_cur;
	wire                in_reset;

	assign in_reset = (state == `JTB_ST_RESET) | ~trst_s[1];

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ir_shift <= `JTB_IR_CAPTURE;
			ir_cur   <= `JTB_OP_IDCODE;
		end
		else if (in_reset)
			ir_cur <= `JTB_OP_IDCODE;
		else if (rise)
		begin
			case (state)
				`JTB_ST_CAP_IR:
					ir_shift <= `JTB_IR_CAPTURE;
				`JTB_ST_SHIFT_IR:
					ir_shift <= {tdi_s[1], ir_shift[`JTB_IR_W-1:1]};
				`JTB_ST_UPD_IR:
					ir_cur <= ir_shift;
				// pause and exit states hold the shifted bits
				default:
					ir_shift <= ir_shift;
			endcase
		end
	end

	// ==========================================
	// data registers in parallel
	reg  [31:0]        id_shift;
	reg                byp;
	reg  [CHAIN_W-1:0] boundary_cell_chain;
	wire               sel_chain;
	wire               sel_id;

	assign sel_chain = (ir_cur == `JTB_OP_EXTEST) | (ir_cur == `JTB_OP_SAMPLE);
	assign sel_id    = (ir_cur == `JTB_OP_IDCODE);

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			id_shift            <= `JTB_IDCODE;
			byp                 <= 1'b0;
			boundary_cell_chain <= {CHAIN_W{1'b0}};
		end
		else if (rise)
		begin
			case (state)
				`JTB_ST_CAP_DR:
				begin
					id_shift            <= `JTB_IDCODE;
					byp                 <= 1'b0;
					// dc pins only, plain level capture
					boundary_cell_chain <= extest_o ? pin_s1 : core_out_i;
				end
				`JTB_ST_SHIFT_DR:
				begin
					if (sel_chain)
						boundary_cell_chain <= {tdi_s[1], boundary_cell_chain[CHAIN_W-1:1]};
					else if (sel_id)
						id_shift <= {tdi_s[1], id_shift[31:1]};
					// unknown opcodes shift through the bypass stage
					else
						byp <= tdi_s[1];
				end
				// registers hold outside capture and shift
				default:
					byp <= byp;
			endcase
		end
	end

	// ==========================================
	// update latches and pin drive
	reg [CHAIN_W-1:0] upd_latch;

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			upd_latch <= {CHAIN_W{1'b0}};
			pin_out_o <= {CHAIN_W{1'b0}};
			extest_o  <= 1'b0;
		end
		else
		begin
			// only chain scans touch the latches, so bypass scans leave the pins alone
			if (rise && state == `JTB_ST_UPD_DR && sel_chain)
				upd_latch <= boundary_cell_chain;
			// extest drives latches to pins at once
			extest_o  <= ~in_reset & (ir_cur == `JTB_OP_EXTEST);
			pin_out_o <= (~in_reset & (ir_cur == `JTB_OP_EXTEST)) ? upd_latch : core_out_i;
		end
	end

	// ==========================================
	// data-out on falling edge
	reg sel_bit;

	always @*
	begin
		if (state == `JTB_ST_SHIFT_IR)
			sel_bit = ir_shift[0];
		// outside shift-ir the current instruction picks the path
		else if (sel_chain)
			sel_bit = boundary_cell_chain[0];
		else if (sel_id)
			sel_bit = id_shift[0];
		else
			sel_bit = byp;
	end

	always @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end
		else if (in_reset)
			tdo_oe_o <= 1'b0;
		else if (fall)
		begin
			tdo_o    <= sel_bit;
			tdo_oe_o <= (state == `JTB_ST_SHIFT_DR) | (state == `JTB_ST_SHIFT_IR);
		end
	end

endmodule // jtb_tap

// *** bench/jtb_tap_checker.sv ***
// assertions on the pins of the test access port
`timescale 1ns/1ps
module jtb_chk #(
	parameter CHAIN_W = 8
)(
	// clock, reset and watched ports
	input wire logic             mclk_i,
	input wire logic             rst_n_i,
	input wire logic             tck_i,
	input wire logic             tms_i,
	input wire logic             trst_n_i,
	input wire logic             tdo_o,
	input wire logic             tdo_oe_o,
	input wire logic             extest_o,
	input wire logic [CHAIN_W-1:0] core_out_i,
	input wire logic [CHAIN_W-1:0] pin_out_o
);
	logic [1:0] tck_s;
	logic [2:0] ones;
	wire        rise = tck_s[0] & ~tck_s[1];

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// counts rises in a row with mode-select high
	always @(posedge mclk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			tck_s <= 2'h0;
			ones  <= 3'h0;
		end
		else
		begin
			tck_s <= {tck_s[0], tck_i};
			if (rise)
				ones <= tms_i ? ones + 3'h1 : 3'h0;
		end

	trst_clear_a: assert property ($fell(trst_n_i) ##1 !trst_n_i[*5] |-> !tdo_oe_o && !extest_o)
		else $error("test reset did not clear the port");
	tdo_fall_a: assert property ($changed(tdo_o) |-> !$past(tck_i, 2) || !$past(tck_i, 3))
		else $error("data out moved away from a falling edge");
	oe_edge_a: assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 2) || !$past(tck_i, 3) || !$past(trst_n_i, 3))
		else $error("output enable moved away from a falling edge");
	oe_width_a: assert property ($rose(tdo_oe_o) |-> tdo_oe_o[*8])
		else $error("shift window shorter than one test clock");
	ext_rise_a: assert property ($rose(extest_o) |-> $past(tck_i, 2) || $past(tck_i, 4))
		else $error("extest began away from a rising edge");
	pin_norm_a: assert property (!extest_o && !$past(extest_o) && !$past(extest_o, 2) && $past(rst_n_i)
		|-> pin_out_o == $past(core_out_i))
		else $error("pins not following the core");
	pin_ext_a: assert property (extest_o && $past(extest_o, 2) && $changed(pin_out_o)
		|-> $past(tck_i, 2) || $past(tck_i, 3))
		else $error("extest pins moved away from an update");
	tms_reset_a: assert property (rise && tms_i && ones == 3'h4 |-> ##[1:6] (!tdo_oe_o && !extest_o))
		else $error("five mode-select ones did not reset");
endmodule // jtb_chk

// *** bench/jtb_tester.sv ***
// board tester model for the test port pins
`timescale 1ns/1ps
module jtb_tester (
	// system clock and test port pins
	input  wire logic mclk_i,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_i,
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o
);
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end

	// levels set half a period before rise
	task tck_step(input logic m, input logic d, output logic q);
		begin
			tms_o = m;
			tdi_o = d;
			repeat (4) @(posedge mclk_i);
			#2 q = tdo_oe_i ? tdo_i : 1'bz;
			tck_o = 1'b1;
			repeat (4) @(posedge mclk_i);
			#2 tck_o = 1'b0;
		end
	endtask

	// idle to shift, n bits lsb first, back to idle
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		begin
			dout = 32'h0;
			tck_step(1'b1, 1'b1, q);
			if (ir)
				tck_step(1'b1, 1'b1, q);
			tck_step(1'b0, 1'b1, q);
			tck_step(1'b0, 1'b1, q);
			for (int i = 0; i < n; i++)
			begin
				tck_step(i == n - 1, din[i], q);
				dout[i] = q;
			end
			tck_step(1'b1, 1'b1, q);
			tck_step(1'b0, 1'b1, q);
		end
	endtask
endmodule // jtb_tester

// *** bench/jtb_tap_tb_top.sv ***
// self-checking bench for the test access port
`timescale 1ns/1ps
`include "jtb_consts.vh"
module jtb_tap_tb_top;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        trst_n_i = 1'b1;
	logic        tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, extest_o, t;
	logic [7:0]  pin_in_i = 8'h5a;
	logic [7:0]  core_out_i = 8'hc3;
	logic [7:0]  pin_out_o;
	logic [31:0] dout;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	jtb_tap jtb_tap_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
		.trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i),
		.core_out_i(core_out_i), .pin_out_o(pin_out_o), .extest_o(extest_o));
	jtb_tester jtb_tester_i (.mclk_i(mclk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .tck_o(tck_i), .tms_o(tms_i),
		.tdi_o(tdi_i));

	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		begin
			samples_checked++;
			if (got !== exp)
			begin
				err_count++;
				$display("Error %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task st(input logic m);
		jtb_tester_i.tck_step(m, 1'b1, t);
	endtask

	task sc(input logic ir, input int n, input logic [31:0] d);
		jtb_tester_i.scan(ir, n, d, dout);
	endtask

	// scan with a pause halfway, through exit2 back into shift
	task pause_scan(input logic ir, input int n, input logic [31:0] din);
		begin
			dout = 32'h0;
			st(1'b1);
			if (ir)
				st(1'b1);
			st(1'b0);
			st(1'b0);
			for (int i = 0; i < n; i++)
			begin
				jtb_tester_i.tck_step(i == n / 2 - 1 || i == n - 1, din[i], t);
				dout[i] = t;
				if (i == n / 2 - 1)
				begin
					st(1'b0);
					st(1'b0);
					st(1'b1);
					st(1'b0);
				end
			end
			st(1'b1);
			st(1'b0);
		end
	endtask

	task t_pause;
		begin
			pause_scan(1'b0, 32, 32'h0);
			chk("idcode via pause", `JTB_IDCODE, dout);
			pause_scan(1'b1, 6, `JTB_OP_SAMPLE);
			chk("ir capture via pause", `JTB_IR_CAPTURE, dout);
			sc(1'b0, 8, 32'h0);
			chk("sample after pause", core_out_i, dout);
		end
	endtask

	task t_idcode;
		begin
			st(1'b0);
			sc(1'b0, 32, 32'h0);
			chk("idcode", `JTB_IDCODE, dout);
		end
	endtask

	task t_bypass;
		begin
			sc(1'b1, 6, `JTB_OP_BYPASS);
			chk("ir capture", `JTB_IR_CAPTURE, dout);
			sc(1'b0, 8, 32'h96);
			chk("bypass", 32'h2c, dout);
		end
	endtask

	task t_extest;
		begin
			sc(1'b1, 6, `JTB_OP_SAMPLE);
			sc(1'b0, 8, 32'h3c);
			chk("sample capture", core_out_i, dout);
			chk("extest off", 1'b0, extest_o);
			sc(1'b1, 6, `JTB_OP_EXTEST);
			chk("preloaded pins", 8'h3c, pin_out_o);
			sc(1'b0, 8, 32'ha5);
			chk("extest capture", pin_in_i, dout);
			chk("updated pins", 8'ha5, pin_out_o);
		end
	endtask

	task t_tms_reset;
		begin
			st(1'b1);
			st(1'b0);
			st(1'b0);
			repeat (4) st(1'b1);
			chk("extest after four", 1'b1, extest_o);
			st(1'b1);
			repeat (2) @(posedge mclk_i);
			#2 chk("extest after five", 1'b0, extest_o);
			chk("normal pins", core_out_i, pin_out_o);
			st(1'b0);
		end
	endtask

	task t_trst;
		begin
			sc(1'b1, 6, `JTB_OP_EXTEST);
			trst_n_i = 1'b0;
			repeat (10) @(posedge mclk_i);
			#2 chk("extest in test reset", 1'b0, extest_o);
			chk("enable in test reset", 1'b0, tdo_oe_o);
			trst_n_i = 1'b1;
		end
	endtask

	initial
	begin
		repeat (20) @(posedge mclk_i);
		#2 rst_n_i = 1'b1;
		t_idcode();
		t_bypass();
		t_extest();
		t_tms_reset();
		t_pause();
		t_trst();
		tally_and_finish();
	end
endmodule // jtb_tap_tb_top

bind jtb_tap jtb_chk #(.CHAIN_W(CHAIN_W)) jtb_chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tck_i(tck_i),
	.tms_i(tms_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .extest_o(extest_o),
	.core_out_i(core_out_i), .pin_out_o(pin_out_o));
